//--- include/fifo_port_defines.vh
// constants for the port timing select and test access port block
`ifndef FIFO_PORT_DEFINES_VH
`define FIFO_PORT_DEFINES_VH
`define SYNC_PIN_COUNT    13
`define IR_WIDTH          4
`define IDCODE_WIDTH      32
`define IR_CAPTURE_VALUE  4'h1
`define IR_IDCODE         4'h2
`define IR_BYPASS         4'hF
`define IDCODE_DEFAULT    32'h0000_0001
`define TMS_RESET_HIGHS   3'h5
`endif

//--- logic/pin_sync.v
// two-flop synchroniser for a group of independent pin levels
`default_nettype none
module pin_sync #(
    parameter W = 1
) (
    input  wire         clk,
    input  wire         rst_n,
    input  wire [W-1:0] pin_in,
    output wire [W-1:0] pin_sync_out
);
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            reg meta_r;
            reg stable_r;
            always @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    meta_r   <= 1'b0;
                    stable_r <= 1'b0;
                end else begin
                    meta_r   <= pin_in[i];
                    stable_r <= meta_r;
                end
            end
            assign pin_sync_out[i] = stable_r;
        end
    endgenerate
endmodule // pin_sync
`default_nettype wire

//--- logic/fifo_port_tap.v
// port timing selection at master reset and the boundary-scan test access port
`default_nettype none
`include "fifo_port_defines.vh"
module fifo_port_tap #(
    parameter [`IDCODE_WIDTH-1:0] IDCODE_VALUE = `IDCODE_DEFAULT // arbitrary value
) (
    input  wire       clk,
    input  wire       arst_n,
    input  wire       master_reset_n,
    input  wire       read_port_timing_select_n,
    input  wire       write_port_timing_select_n,
    input  wire       rclk_rd,
    input  wire       ren_n,
    input  wire       wclk_wr,
    input  wire       wen_n,
    input  wire       tck,
    input  wire       tms,
    input  wire       tms_open,
    input  wire       tdi,
    input  wire       tdi_open,
    input  wire       trst_n,
    output reg        sync_read_mode_r,
    output reg        sync_write_mode_r,
    output reg        read_word_r,
    output reg        write_word_r,
    output reg        data_out_oe_r,
    output reg        tap_ready_r,
    output reg  [3:0] tap_state_r,
    output reg        tdo_r,
    output reg        tdo_oe_r
);
    localparam [3:0] S_TLR  = 4'h0;
    localparam [3:0] S_RTI  = 4'h1;
    localparam [3:0] S_SDRS = 4'h2;
    localparam [3:0] S_CDR  = 4'h3;
    localparam [3:0] S_SDR  = 4'h4;
    localparam [3:0] S_E1DR = 4'h5;
    localparam [3:0] S_PDR  = 4'h6;
    localparam [3:0] S_E2DR = 4'h7;
    localparam [3:0] S_UDR  = 4'h8;
    localparam [3:0] S_SIRS = 4'h9;
    localparam [3:0] S_CIR  = 4'hA;
    localparam [3:0] S_SIR  = 4'hB;
    localparam [3:0] S_E1IR = 4'hC;
    localparam [3:0] S_PIR  = 4'hD;
    localparam [3:0] S_E2IR = 4'hE;
    localparam [3:0] S_UIR  = 4'hF;

    // block reset: asynchronous assert, released through two flops
    reg  [1:0] rst_pipe_r;
    wire       rst_n;
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_pipe_r <= 2'b00;
        end else begin
            rst_pipe_r <= {rst_pipe_r[0], 1'b1};
        end
    end
    assign rst_n = rst_pipe_r[1];

    // test reset asserts at once, without any tck edge, and releases through two flops
    reg  [1:0] trst_pipe_r;
    wire       tap_rst_n;
    always @(posedge clk or negedge trst_n) begin
        if (!trst_n) begin
            trst_pipe_r <= 2'b00;
        end else begin
            trst_pipe_r <= {trst_pipe_r[0], 1'b1};
        end
    end
    assign tap_rst_n = trst_pipe_r[1] & rst_n;

    // every pin level crosses into clk through two flops; both resets go in inverted so
    // a cleared synchroniser reads as reset released, never as a false reset
    wire [`SYNC_PIN_COUNT-1:0] pins_s;
    pin_sync #(
        .W (`SYNC_PIN_COUNT)
    ) u_sync (
        .clk          (clk),
        .rst_n        (rst_n),
        .pin_in       ({~trst_n, tdi_open, tms_open, tdi, tms, tck, wen_n, wclk_wr, ren_n, rclk_rd,
                        write_port_timing_select_n, read_port_timing_select_n, ~master_reset_n}),
        .pin_sync_out (pins_s)
    );
    wire mrs_n_s   = ~pins_s[0];
    wire rsel_s    = pins_s[1];
    wire wsel_s    = pins_s[2];
    wire rclk_s    = pins_s[3];
    wire ren_n_s   = pins_s[4];
    wire wclk_s    = pins_s[5];
    wire wen_n_s   = pins_s[6];
    wire tck_s     = pins_s[7];
    wire tms_raw_s = pins_s[8];
    wire tdi_raw_s = pins_s[9];
    wire tms_s     = tms_raw_s | pins_s[10];
    wire tdi_s     = tdi_raw_s | pins_s[11];
    wire trst_n_s  = ~pins_s[12];

    // edge finders look only at synchronised copies
    reg  tck_d_r;
    reg  rclk_d_r;
    reg  wclk_d_r;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tck_d_r  <= 1'b0;
            rclk_d_r <= 1'b0;
            wclk_d_r <= 1'b0;
        end else begin
            tck_d_r  <= tck_s;
            rclk_d_r <= rclk_s;
            wclk_d_r <= wclk_s;
        end
    end
    wire tck_rise  = tck_s & ~tck_d_r;
    wire tck_fall  = ~tck_s & tck_d_r;
    wire rclk_rise = rclk_s & ~rclk_d_r;
    wire wclk_rise = wclk_s & ~wclk_d_r;

    // port timing selection; pins are meant to stay put after master reset, so only
    // the value seen while reset is held counts
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_read_mode_r  <= 1'b1;
            sync_write_mode_r <= 1'b1;
        end else if (!mrs_n_s) begin
            sync_read_mode_r  <= rsel_s;
            sync_write_mode_r <= wsel_s;
        end
    end

    // one word per qualified edge; async mode ignores the enables, which are tied active
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            read_word_r  <= 1'b0;
        end else begin
            read_word_r  <= mrs_n_s & rclk_rise & (~sync_read_mode_r | ~ren_n_s);
        end
    end

    // nothing is written while master reset is held, whatever the strobe does
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            write_word_r <= 1'b0;
        end else begin
            write_word_r <= mrs_n_s & wclk_rise & (~sync_write_mode_r | ~wen_n_s);
        end
    end

    // controller next state
    reg [3:0] state_nxt;
    always @* begin
        case (tap_state_r)
            S_TLR:   state_nxt = tms_s ? S_TLR  : S_RTI;
            S_RTI:   state_nxt = tms_s ? S_SDRS : S_RTI;
            S_SDRS:  state_nxt = tms_s ? S_SIRS : S_CDR;
            S_CDR:   state_nxt = tms_s ? S_E1DR : S_SDR;
            S_SDR:   state_nxt = tms_s ? S_E1DR : S_SDR;
            S_E1DR:  state_nxt = tms_s ? S_UDR  : S_PDR;
            S_PDR:   state_nxt = tms_s ? S_E2DR : S_PDR;
            S_E2DR:  state_nxt = tms_s ? S_UDR  : S_SDR;
            S_UDR:   state_nxt = tms_s ? S_SDRS : S_RTI;
            S_SIRS:  state_nxt = tms_s ? S_TLR  : S_CIR;
            S_CIR:   state_nxt = tms_s ? S_E1IR : S_SIR;
            S_SIR:   state_nxt = tms_s ? S_E1IR : S_SIR;
            S_E1IR:  state_nxt = tms_s ? S_UIR  : S_PIR;
            S_PIR:   state_nxt = tms_s ? S_E2IR : S_PIR;
            S_E2IR:  state_nxt = tms_s ? S_UIR  : S_SIR;
            S_UIR:   state_nxt = tms_s ? S_SDRS : S_RTI;
            default: state_nxt = S_TLR;
        endcase
    end

    // state and scan registers advance only on a tck rise
    reg  [`IR_WIDTH-1:0]     ir_shift_r;
    reg  [`IR_WIDTH-1:0]     ir_r;
    reg  [`IDCODE_WIDTH-1:0] id_shift_r;
    reg                      bypass_r;
    wire                     sel_id = (ir_r == `IR_IDCODE);
    always @(posedge clk or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            tap_state_r <= S_TLR;
            ir_shift_r  <= `IR_CAPTURE_VALUE;
            ir_r        <= `IR_IDCODE;
            id_shift_r  <= IDCODE_VALUE;
            bypass_r    <= 1'b0;
        end else if (tck_rise) begin
            tap_state_r <= state_nxt;
            case (tap_state_r)
                S_TLR: begin
                    ir_r <= `IR_IDCODE;
                end
                S_CIR: begin
                    ir_shift_r <= `IR_CAPTURE_VALUE;
                end
                S_SIR: begin
                    ir_shift_r <= {tdi_s, ir_shift_r[`IR_WIDTH-1:1]};
                end
                S_UIR: begin
                    ir_r <= ir_shift_r;
                end
                S_CDR: begin
                    id_shift_r <= IDCODE_VALUE;
                    bypass_r   <= 1'b0;
                end
                S_SDR: begin
                    if (sel_id) begin
                        id_shift_r <= {tdi_s, id_shift_r[`IDCODE_WIDTH-1:1]};
                    end else begin
                        bypass_r <= tdi_s;
                    end
                end
                default: begin
                    bypass_r <= bypass_r;
                end
            endcase
        end
    end

    // count tms highs in a row; only five of them reach test-logic-reset from any
    // state, while a shorter run may pass through it from a state not yet known;
    // the count saturates so a long run of highs keeps the walk marked done
    reg  [2:0] tms_ones_r;
    wire       tms_walk_done = (tms_ones_r == `TMS_RESET_HIGHS);
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tms_ones_r <= 3'h0;
        end else if (tck_rise) begin
            if (!tms_s) begin
                tms_ones_r <= 3'h0;
            end else if (!tms_walk_done) begin
                tms_ones_r <= tms_ones_r + 3'h1;
            end
        end
    end

    // the power-up state is not trusted: only a test reset or the tms walk into
    // test-logic-reset marks the controller as known
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tap_ready_r <= 1'b0;
        end else if (!trst_n_s) begin
            tap_ready_r <= 1'b1;
        end else if (tms_walk_done) begin
            tap_ready_r <= 1'b1;
        end
    end

    // fifo data outputs stay released until the controller is known
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            data_out_oe_r <= 1'b0;
        end else begin
            data_out_oe_r <= tap_ready_r;
        end
    end

    // tdo and its enable move on the falling edge, half a tck after the shift
    wire shifting_ir = (tap_state_r == S_SIR);
    wire shifting_dr = (tap_state_r == S_SDR);
    reg  tdo_nxt;
    reg  tdo_oe_nxt;
    // worked out every cycle but taken only on a tck fall, so tdo holds through the
    // whole half period in which the board controller samples it
    always @* begin
        tdo_oe_nxt = tap_ready_r & (shifting_ir | shifting_dr);
        if (shifting_ir) begin
            tdo_nxt = ir_shift_r[0];
        end else if (sel_id) begin
            tdo_nxt = id_shift_r[0];
        end else begin
            tdo_nxt = bypass_r;
        end
    end

    // test reset drops the enable at once; it comes back only on a later shift
    always @(posedge clk or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            tdo_r    <= 1'b0;
            tdo_oe_r <= 1'b0;
        end else if (tck_fall) begin
            tdo_oe_r <= tdo_oe_nxt;
            tdo_r    <= tdo_nxt;
        end
    end
endmodule // fifo_port_tap
`default_nettype wire

//--- testbench/fifo_port_tap_props.sv
// assertions on the port timing select and test port block
`default_nettype none
module fifo_port_tap_props (
    input wire logic       clk,
    input wire logic       arst_n,
    input wire logic       master_reset_n,
    input wire logic       read_port_timing_select_n,
    input wire logic       write_port_timing_select_n,
    input wire logic       tck,
    input wire logic       trst_n,
    input wire logic       sync_read_mode_r,
    input wire logic       sync_write_mode_r,
    input wire logic       read_word_r,
    input wire logic       write_word_r,
    input wire logic       data_out_oe_r,
    input wire logic       tap_ready_r,
    input wire logic [3:0] tap_state_r,
    input wire logic       tdo_r,
    input wire logic       tdo_oe_r
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    rd_mode_hold_a:
        assert property (master_reset_n [*8] |-> $stable(sync_read_mode_r)) else $error("read mode moved");
    rd_mode_take_a:
        assert property ((!master_reset_n && read_port_timing_select_n) [*6] |-> sync_read_mode_r)
            else $error("read mode not taken");
    wr_mode_take_a:
        assert property ((!master_reset_n && !write_port_timing_select_n) [*6] |-> !sync_write_mode_r)
            else $error("write mode not taken");
    tdo_on_fall_a:
        assert property (($changed(tdo_r) && trst_n && $past(trst_n)) |-> !tck) else $error("tdo moved, tck high");
    oe_shift_only_a:
        assert property ($rose(tdo_oe_r) |-> tap_state_r == 4'h4 || tap_state_r == 4'hB)
            else $error("tdo driven outside shift");
    trst_clear_a:
        assert property (!trst_n |-> tap_state_r == 4'h0 && !tdo_oe_r) else $error("test reset ignored");
    step_on_rise_a:
        assert property (($changed(tap_state_r) && trst_n && $past(trst_n)) |-> $past(tck, 3))
            else $error("state moved without tck rise");
    read_pulse_a:
        assert property (read_word_r |=> !read_word_r) else $error("read pulse too long");
    busy_reset_a:
        assert property (!master_reset_n [*5] |-> !read_word_r && !write_word_r) else $error("word during reset");
    out_off_a:
        assert property (data_out_oe_r |-> tap_ready_r) else $error("outputs on before tap reset");
    cover property (read_word_r);
    cover property ($rose(tdo_oe_r));
    cover property ($rose(tap_ready_r));
endmodule // fifo_port_tap_props
bind fifo_port_tap fifo_port_tap_props fifo_port_tap_props_inst (.clk, .arst_n, .master_reset_n,
    .read_port_timing_select_n, .write_port_timing_select_n, .tck, .trst_n, .sync_read_mode_r,
    .sync_write_mode_r, .read_word_r, .write_word_r, .data_out_oe_r, .tap_ready_r, .tap_state_r, .tdo_r, .tdo_oe_r);
`default_nettype wire

//--- testbench/scan_model.sv
// board test controller model driving the test port pins
`default_nettype none
module scan_model (
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    output logic      trst_n,
    input  wire logic tdo,
    input  wire logic tdo_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
        trst_n = 1'b1;
    end
    // tdo read just before the rise; a released tdo reads unknown
    // pins move by non-blocking assignment on clk edges, so the synchronisers never race them
    task step(input logic m, input logic d, output logic o);
        tms <= m;
        tdi <= d;
        #80;
        o = tdo_oe ? tdo : 1'bx;
        tck <= 1'b1;
        #80;
        tck <= 1'b0;
    endtask
    task pulse_trst;
        trst_n <= 1'b0;
        #100;
        trst_n <= 1'b1;
    endtask
endmodule // scan_model
`default_nettype wire

//--- testbench/testbench.sv
// self-checking bench for the port timing select and test port block
`default_nettype none
`include "fifo_port_defines.vh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0, arst_n = 1'b0, master_reset_n, read_port_timing_select_n, write_port_timing_select_n;
    logic        rclk_rd, ren_n, wclk_wr, wen_n, tms_open, tdi_open, o;
    wire         tck, tms, tdi, trst_n, sync_read_mode_r, sync_write_mode_r, read_word_r, write_word_r;
    wire         data_out_oe_r, tap_ready_r, tdo_r, tdo_oe_r;
    wire  [3:0]  tap_state_r;
    logic [31:0] got, din;
    integer      seed = 32'h20a8_68bf, mismatches = 0, check_count = 0, rd_cnt = 0, wr_cnt = 0;
    fifo_port_tap fifo_port_tap_inst (.clk, .arst_n, .master_reset_n, .read_port_timing_select_n,
        .write_port_timing_select_n, .rclk_rd, .ren_n, .wclk_wr, .wen_n, .tck, .tms, .tms_open, .tdi, .tdi_open,
        .trst_n, .sync_read_mode_r, .sync_write_mode_r, .read_word_r, .write_word_r, .data_out_oe_r, .tap_ready_r,
        .tap_state_r, .tdo_r, .tdo_oe_r);
    scan_model scan_model_inst (.tck, .tms, .tdi, .trst_n, .tdo(tdo_r), .tdo_oe(tdo_oe_r));
    always #5 clk = ~clk;
    always @(posedge clk) begin
        rd_cnt <= rd_cnt + (read_word_r === 1'b1);
        wr_cnt <= wr_cnt + (write_word_r === 1'b1);
    end
    task chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task end_sim;
        $display("mismatches=%0d checks=%0d", mismatches, check_count);
        if (mismatches == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task clks(input int n);
        repeat (n) @(posedge clk);
    endtask
    task scan(input logic [31:0] tm, input logic [31:0] d, input int n);
        got = '0;
        for (int i = 0; i < n; i++) begin
            scan_model_inst.step(tm[i], d[i], o);
            got[i] = o;
        end
        clks(1);
    endtask
    // strobes high and low three clocks each, above the two-clock minimum
    task port_run(input logic rs, input logic ws);
        int n, r0, w0, er, ew;
        logic e;
        master_reset_n <= 1'b0;
        read_port_timing_select_n <= rs;
        write_port_timing_select_n <= ws;
        clks(8);
        chk(sync_read_mode_r, rs);
        chk(sync_write_mode_r, ws);
        master_reset_n <= 1'b1;
        clks(8);
        read_port_timing_select_n <= ~rs;
        write_port_timing_select_n <= ~ws;
        clks(8);
        chk(sync_read_mode_r, rs);
        chk(sync_write_mode_r, ws);
        r0 = rd_cnt;
        w0 = wr_cnt;
        er = 0;
        ew = 0;
        din = $random(seed);
        n = 3 + din[1:0];
        repeat (n) begin
            din = $random(seed);
            e = din[0];
            ren_n <= rs ? e : 1'b0;
            wen_n <= ws ? ~e : 1'b0;
            er += (!rs || !e);
            ew += (!ws || e);
            clks(3);
            rclk_rd <= 1'b1;
            wclk_wr <= 1'b1;
            clks(3);
            rclk_rd <= 1'b0;
            wclk_wr <= 1'b0;
        end
        clks(6);
        chk(rd_cnt - r0, er);
        chk(wr_cnt - w0, ew);
    endtask
    initial begin
        repeat (100000) @(posedge clk);
        mismatches++;
        end_sim;
    end
    initial begin
        master_reset_n = 1'b0;
        read_port_timing_select_n = 1'b1;
        write_port_timing_select_n = 1'b1;
        {rclk_rd, ren_n, wclk_wr, wen_n, tms_open, tdi_open} = 6'h00;
        clks(20);
        arst_n <= 1'b1;
        clks(6);
        chk(tap_ready_r, 1'b0);
        chk(data_out_oe_r, 1'b0);
        for (int k = 0; k < 4; k++)
            port_run(k[0], k[1]);
        tms_open <= 1'b1;
        scan(32'h0, 32'h0, 4);
        chk(tap_ready_r, 1'b0);
        scan(32'h0, 32'h0, 1);
        tms_open <= 1'b0;
        chk(tap_state_r, 4'h0);
        chk(tap_ready_r, 1'b1);
        chk(data_out_oe_r, 1'b1);
        scan(32'h2, 32'h0, 4);
        chk(tap_state_r, 4'h4);
        din = $random(seed);
        scan(32'h8000_0000, din, 32);
        chk(got, `IDCODE_DEFAULT);
        scan(32'h1, 32'h0, 2);
        scan(32'h3, 32'h0, 4);
        chk(tap_state_r, 4'hB);
        tdi_open <= 1'b1;
        scan(32'h8, 32'h2, 4);
        tdi_open <= 1'b0;
        chk(got[3:0], `IR_CAPTURE_VALUE);
        scan(32'h1, 32'h0, 2);
        scan(32'h1, 32'h0, 3);
        din = $random(seed);
        scan(32'h80, din, 8);
        chk(got[7:0], {din[6:0], 1'b0});
        clks(4);
        chk(tdo_oe_r, 1'b0);
        scan_model_inst.pulse_trst();
        clks(4);
        chk(tap_state_r, 4'h0);
        scan(32'h2, 32'h0, 4);
        scan(32'h8000_0000, din, 32);
        chk(got, `IDCODE_DEFAULT);
        end_sim;
    end
endmodule // testbench
`default_nettype wire
